// file: epqs_pkg.sv
// package: register map, field layout and sizes of the priority queue screener
package epqs_pkg;
    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_QUEUES    = 4;
    localparam int NUM_T1        = 4;
    localparam int NUM_T2        = 8;
    localparam int NUM_ETYPE     = 4;
    localparam int NUM_CW        = 8;
    localparam int QW            = 2;
    localparam int ADDR_W        = 12;
    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] RX_QUEUE0_BASE_OFF = 12'h018;
    localparam logic [11:0] TX_QUEUE0_BASE_OFF = 12'h01c;
    localparam logic [11:0] TX_QUEUE1_BASE_OFF = 12'h440;
    localparam logic [11:0] RX_QUEUE1_BASE_OFF = 12'h480;
    localparam logic [11:0] T1_SCREEN_OFF      = 12'h500;
    localparam logic [11:0] T2_SCREEN_OFF      = 12'h540;
    localparam logic [11:0] ETYPE_MATCH_OFF    = 12'h6e0;
    localparam logic [11:0] COMPARE_WORD_OFF   = 12'h700;
    localparam logic [11:0] SHAPE_CTRL_OFF     = 12'h800;
    localparam logic [11:0] SHAPE_CREDIT_OFF   = 12'h804;
    localparam logic [11:0] REGION_SIZE_OFF    = 12'h810;
    localparam logic [11:0] STATUS_OFF         = 12'h820;
    localparam logic [31:0] RESET_WORD         = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_WORD      = 32'h0000_0000;
    // ------------------------------------------------------------------
    // first-type screener fields
    // ------------------------------------------------------------------
    localparam int T1_Q_LSB      = 0;   // queue [1:0]
    localparam int T1_DS_LSB     = 4;   // ds/tc value [11:4]
    localparam int T1_DS_EN      = 28;
    localparam int T1_UDP_EN     = 29;
    localparam int T1_UDP_LSB    = 12;  // udp port [27:12]
    localparam int T1_EN         = 31;
    // ------------------------------------------------------------------
    // second-type screener fields
    // ------------------------------------------------------------------
    localparam int T2_Q_LSB      = 0;
    localparam int T2_VLAN_PRIORITY_VALUE_LSB  = 4;   // [6:4]
    localparam int T2_VLAN_PRIORITY_MATCH_ENABLE      = 8;
    localparam int T2_ETSEL_LSB  = 9;   // [10:9]
    localparam int T2_ETHERTYPE_MATCH_ENABLE       = 11;
    localparam int T2_CA_LSB     = 12;  // [14:12]
    localparam int T2_CAE        = 15;
    localparam int T2_CB_LSB     = 16;
    localparam int T2_CBE        = 19;
    localparam int T2_CC_LSB     = 20;
    localparam int T2_CCE        = 23;
    localparam int T2_EN         = 31;
endpackage

// file: epqs_frame_if.sv
// interface: received frame header fields and screening verdict
`timescale 1ns/1ps
`default_nettype none
interface epqs_frame_if;
    logic        valid;
    logic        ds_valid;
    logic [7:0]  ds;
    logic        udp_valid;
    logic [15:0] udp_port;
    logic        vlan_valid;
    logic [2:0]  vlan_prio;
    logic [15:0] ethertype;
    logic [31:0] payload_word;
    logic [1:0]  queue;
    logic        matched;
    modport screener (input  valid, ds_valid, ds, udp_valid, udp_port,
                      input  vlan_valid, vlan_prio, ethertype,
                      input  payload_word,
                      output queue, matched);
    modport source   (output valid, ds_valid, ds, udp_valid, udp_port,
                      output vlan_valid, vlan_prio, ethertype,
                      output payload_word,
                      input  queue, matched);
endinterface
`default_nettype wire

// file: epqs_screener.sv
// screening logic: first- and second-type screeners resolve a queue
`timescale 1ns/1ps
`default_nettype none
module epqs_screener
(
    // screener configuration
    input  wire logic [epqs_pkg::NUM_T1-1:0][31:0]    t1_cfg,
    input  wire logic [epqs_pkg::NUM_T2-1:0][31:0]    t2_cfg,
    input  wire logic [epqs_pkg::NUM_ETYPE-1:0][15:0] etype_match,
    input  wire logic [epqs_pkg::NUM_CW-1:0][31:0]    compare_word,
    // frame fields and verdict
    epqs_frame_if.screener                            frm
);
    // ------------------------------------------------------------------
    // per-screener match
    // ------------------------------------------------------------------
    localparam int NS = epqs_pkg::NUM_T1 + epqs_pkg::NUM_T2;
    wire logic [NS-1:0]      hit;
    wire logic [NS-1:0][1:0] hit_q;

    genvar i;
    generate
        for (i = 0; i < epqs_pkg::NUM_T1; i++)
        begin : g_t1
            wire logic [31:0] c = t1_cfg[i];
            wire logic ds_ok  = !c[epqs_pkg::T1_DS_EN] || (frm.ds_valid &&
                frm.ds == c[epqs_pkg::T1_DS_LSB +: 8]);
            wire logic udp_ok = !c[epqs_pkg::T1_UDP_EN] || (frm.udp_valid &&
                frm.udp_port == c[epqs_pkg::T1_UDP_LSB +: 16]);
            assign hit[i]   = c[epqs_pkg::T1_EN] && ds_ok && udp_ok;
            assign hit_q[i] = c[epqs_pkg::T1_Q_LSB +: 2];
        end
        for (i = 0; i < epqs_pkg::NUM_T2; i++)
        begin : g_t2
            wire logic [31:0] c = t2_cfg[i];
            wire logic vl_ok = !c[epqs_pkg::T2_VLAN_PRIORITY_MATCH_ENABLE] || (frm.vlan_valid &&
                frm.vlan_prio == c[epqs_pkg::T2_VLAN_PRIORITY_VALUE_LSB +: 3]);
            wire logic et_ok = !c[epqs_pkg::T2_ETHERTYPE_MATCH_ENABLE] || (frm.ethertype ==
                etype_match[c[epqs_pkg::T2_ETSEL_LSB +: 2]]);
            wire logic ca_ok = !c[epqs_pkg::T2_CAE] || (frm.payload_word ==
                compare_word[c[epqs_pkg::T2_CA_LSB +: 3]]);
            wire logic cb_ok = !c[epqs_pkg::T2_CBE] || (frm.payload_word ==
                compare_word[c[epqs_pkg::T2_CB_LSB +: 3]]);
            wire logic cc_ok = !c[epqs_pkg::T2_CCE] || (frm.payload_word ==
                compare_word[c[epqs_pkg::T2_CC_LSB +: 3]]);
            assign hit[epqs_pkg::NUM_T1+i] = c[epqs_pkg::T2_EN] &&
                vl_ok && et_ok && ca_ok && cb_ok && cc_ok;
            assign hit_q[epqs_pkg::NUM_T1+i] = c[epqs_pkg::T2_Q_LSB +: 2];
        end
    endgenerate

    // ------------------------------------------------------------------
    // lowest address wins
    // ------------------------------------------------------------------
    logic [1:0] pick;
    always_comb
    begin
        pick = 2'h0;
        for (int k = NS - 1; k >= 0; k--)
            if (hit[k])
                pick = hit_q[k];
    end
    assign frm.queue   = pick;
    assign frm.matched = |hit;
endmodule
`default_nettype wire

// file: epqs_top.sv
// top: register file, receive queue tagging and transmit priority select
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module epqs_top
#(
    parameter int NUM_QUEUES = epqs_pkg::NUM_QUEUES
)
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // avalon-mm slave
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // received frame header from the mac
    input  wire logic        rx_valid,
    input  wire logic        rx_ds_valid,
    input  wire logic [7:0]  rx_ds,
    input  wire logic        rx_udp_valid,
    input  wire logic [15:0] rx_udp_port,
    input  wire logic        rx_vlan_valid,
    input  wire logic [2:0]  rx_vlan_prio,
    input  wire logic [15:0] rx_ethertype,
    input  wire logic [31:0] rx_payload_word,
    // receive tag to the dma
    output logic             rx_tag_valid,
    output logic      [1:0]  rx_tag_queue,
    output logic      [31:0] rx_tag_base,
    output logic             rx_tag_matched,
    // transmit: per-queue fetched frames waiting, mac ready
    input  wire logic [NUM_QUEUES-1:0] tx_pending,
    input  wire logic        tx_mac_ready,
    output logic             tx_grant_valid,
    output logic      [1:0]  tx_grant_queue,
    output logic      [31:0] tx_grant_base,
    output logic      [15:0] tx_grant_region
);
    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (NUM_QUEUES != epqs_pkg::NUM_QUEUES)
        $error("epqs_top: queue count must match the 2-bit queue field");

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [NUM_QUEUES-1:0][31:0] tx_base;
    logic [NUM_QUEUES-1:0][31:0] rx_base;
    logic [epqs_pkg::NUM_T1-1:0][31:0]    t1_cfg;
    logic [epqs_pkg::NUM_T2-1:0][31:0]    t2_cfg;
    logic [epqs_pkg::NUM_ETYPE-1:0][15:0] etype_match;
    logic [epqs_pkg::NUM_CW-1:0][31:0]    compare_word;
    logic [NUM_QUEUES-1:0]       shape_en;
    logic [NUM_QUEUES-1:0][7:0]  credit;
    logic [NUM_QUEUES-1:0][15:0] region_size;
    logic [NUM_QUEUES-1:0][31:0] rx_count;
    logic                        ack;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire logic        req    = (avs_read || avs_write) && !ack;
    wire logic        wr     = avs_write && !ack;
    wire logic [11:0] a      = {avs_address[11:2], 2'b00};
    wire logic [9:0]  widx   = a[11:2];
    wire logic        hit_rx0 = a == epqs_pkg::RX_QUEUE0_BASE_OFF;
    wire logic        hit_tx0 = a == epqs_pkg::TX_QUEUE0_BASE_OFF;
    wire logic [9:0]  tx_i = widx - epqs_pkg::TX_QUEUE1_BASE_OFF[11:2];
    wire logic [9:0]  rx_i = widx - epqs_pkg::RX_QUEUE1_BASE_OFF[11:2];
    wire logic [9:0]  t1_i = widx - epqs_pkg::T1_SCREEN_OFF[11:2];
    wire logic [9:0]  t2_i = widx - epqs_pkg::T2_SCREEN_OFF[11:2];
    wire logic [9:0]  et_i = widx - epqs_pkg::ETYPE_MATCH_OFF[11:2];
    wire logic [9:0]  cw_i = widx - epqs_pkg::COMPARE_WORD_OFF[11:2];
    wire logic [9:0]  rg_i = widx - epqs_pkg::REGION_SIZE_OFF[11:2];
    wire logic [9:0]  st_i = widx - epqs_pkg::STATUS_OFF[11:2];
    wire logic hit_txn = tx_i < 10'(NUM_QUEUES - 1);
    wire logic hit_rxn = rx_i < 10'(NUM_QUEUES - 1);
    wire logic hit_t1  = t1_i < 10'(epqs_pkg::NUM_T1);
    wire logic hit_t2  = t2_i < 10'(epqs_pkg::NUM_T2);
    wire logic hit_et  = et_i < 10'(epqs_pkg::NUM_ETYPE);
    wire logic hit_cw  = cw_i < 10'(epqs_pkg::NUM_CW);
    wire logic hit_rg  = rg_i < 10'(NUM_QUEUES);
    wire logic hit_st  = st_i < 10'(NUM_QUEUES);
    wire logic hit_sc  = a == epqs_pkg::SHAPE_CTRL_OFF;
    wire logic hit_cr  = a == epqs_pkg::SHAPE_CREDIT_OFF;
    wire logic [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = epqs_pkg::UNMAPPED_WORD;
        if (hit_rx0)
            next_rdata = rx_base[0];
        else if (hit_tx0)
            next_rdata = tx_base[0];
        else if (hit_txn)
            next_rdata = tx_base[tx_i[1:0] + 2'd1];
        else if (hit_rxn)
            next_rdata = rx_base[rx_i[1:0] + 2'd1];
        else if (hit_t1)
            next_rdata = t1_cfg[t1_i[1:0]];
        else if (hit_t2)
            next_rdata = t2_cfg[t2_i[2:0]];
        else if (hit_et)
            next_rdata = {16'h0000, etype_match[et_i[1:0]]};
        else if (hit_cw)
            next_rdata = compare_word[cw_i[2:0]];
        else if (hit_sc)
            next_rdata = {28'h0000000, shape_en};
        else if (hit_cr)
            next_rdata = credit;
        else if (hit_rg)
            next_rdata = {16'h0000, region_size[rg_i[1:0]]};
        else if (hit_st)
            next_rdata = rx_count[st_i[1:0]];
    end

    // one wait cycle per access: answer on the second edge
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            ack          <= 1'b0;
            avs_readdata <= epqs_pkg::RESET_WORD;
        end
        else
        begin
            ack          <= req;
            avs_readdata <= req ? next_rdata : avs_readdata;
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            tx_base      <= '0;
            rx_base      <= '0;
            t1_cfg       <= '0;
            t2_cfg       <= '0;
            etype_match  <= '0;
            compare_word <= '0;
            shape_en     <= '0;
            credit       <= '0;
            region_size  <= '0;
        end
        else if (wr)
        begin
            if (hit_rx0)
                rx_base[0] <= merge(rx_base[0], avs_writedata, bmask);
            if (hit_tx0)
                tx_base[0] <= merge(tx_base[0], avs_writedata, bmask);
            if (hit_txn)
                tx_base[tx_i[1:0] + 2'd1] <= merge(tx_base[tx_i[1:0] + 2'd1],
                    avs_writedata, bmask);
            if (hit_rxn)
                rx_base[rx_i[1:0] + 2'd1] <= merge(rx_base[rx_i[1:0] + 2'd1],
                    avs_writedata, bmask);
            if (hit_t1)
                t1_cfg[t1_i[1:0]] <= merge(t1_cfg[t1_i[1:0]],
                    avs_writedata, bmask);
            if (hit_t2)
                t2_cfg[t2_i[2:0]] <= merge(t2_cfg[t2_i[2:0]],
                    avs_writedata, bmask);
            if (hit_et)
                etype_match[et_i[1:0]] <= 16'(merge({16'h0000,
                    etype_match[et_i[1:0]]}, avs_writedata, bmask));
            if (hit_cw)
                compare_word[cw_i[2:0]] <= merge(compare_word[cw_i[2:0]],
                    avs_writedata, bmask);
            if (hit_sc)
                shape_en <= 4'(merge({28'h0000000, shape_en},
                    avs_writedata, bmask));
            if (hit_cr)
                credit <= merge(credit, avs_writedata, bmask);
            if (hit_rg)
                region_size[rg_i[1:0]] <= 16'(merge({16'h0000,
                    region_size[rg_i[1:0]]}, avs_writedata, bmask));
        end
    end

    // ------------------------------------------------------------------
    // receive screening
    // ------------------------------------------------------------------
    epqs_frame_if frm ();
    assign frm.valid        = rx_valid;
    assign frm.ds_valid     = rx_ds_valid;
    assign frm.ds           = rx_ds;
    assign frm.udp_valid    = rx_udp_valid;
    assign frm.udp_port     = rx_udp_port;
    assign frm.vlan_valid   = rx_vlan_valid;
    assign frm.vlan_prio    = rx_vlan_prio;
    assign frm.ethertype    = rx_ethertype;
    assign frm.payload_word = rx_payload_word;

    epqs_screener u_screener
    (
        .t1_cfg       (t1_cfg),
        .t2_cfg       (t2_cfg),
        .etype_match  (etype_match),
        .compare_word (compare_word),
        .frm          (frm)
    );

    // frames tagged in arrival order, one per cycle, no reordering
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            rx_tag_valid   <= 1'b0;
            rx_tag_queue   <= 2'h0;
            rx_tag_base    <= 32'h0000_0000;
            rx_tag_matched <= 1'b0;
            rx_count       <= '0;
        end
        else
        begin
            rx_tag_valid <= rx_valid;
            if (rx_valid)
            begin
                rx_tag_queue   <= frm.queue;
                rx_tag_base    <= rx_base[frm.queue];
                rx_tag_matched <= frm.matched;
                rx_count[frm.queue] <= rx_count[frm.queue] + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // transmit priority select
    // ------------------------------------------------------------------
    // highest queue index is highest priority; shaped queues need credit
    wire logic [NUM_QUEUES-1:0] eligible;
    genvar q;
    generate
        for (q = 0; q < NUM_QUEUES; q++)
        begin : g_elig
            assign eligible[q] = tx_pending[q] &&
                (!shape_en[q] || credit[q] != 8'h00);
        end
    endgenerate

    logic [1:0] next_q;
    always_comb
    begin
        next_q = 2'h0;
        for (int k = 0; k < NUM_QUEUES; k++)
            if (eligible[k])
                next_q = 2'(k);
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            tx_grant_valid  <= 1'b0;
            tx_grant_queue  <= 2'h0;
            tx_grant_base   <= 32'h0000_0000;
            tx_grant_region <= 16'h0000;
        end
        else
        begin
            tx_grant_valid <= tx_mac_ready && |eligible;
            if (tx_mac_ready && |eligible)
            begin
                tx_grant_queue  <= next_q;
                tx_grant_base   <= tx_base[next_q];
                tx_grant_region <= region_size[next_q];
            end
        end
    end
endmodule
`default_nettype wire

// file: epqs_sva.sv
// checker: port timing of the priority queue screener
`timescale 1ns/1ps
`default_nettype none
module epqs_sva
#(
    parameter int NUM_QUEUES = 4
)
(
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  reset_n,
    // bus and frame side
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic                  avs_waitrequest,
    input wire logic                  rx_valid,
    input wire logic                  rx_tag_valid,
    input wire logic [1:0]            rx_tag_queue,
    input wire logic                  rx_tag_matched,
    // transmit side
    input wire logic [NUM_QUEUES-1:0] tx_pending,
    input wire logic                  tx_mac_ready,
    input wire logic                  tx_grant_valid,
    input wire logic [1:0]            tx_grant_queue
);
    logic [NUM_QUEUES-1:0] pend_q;
    logic                  rdy_q;
    wire                   req = avs_read | avs_write;
    always_ff @(posedge core_clk)
    begin
        pend_q <= reset_n ? tx_pending : '0;
        rdy_q  <= reset_n & tx_mac_ready;
    end
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
        else $error("no wait cycle on new request");
    a_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("second wait cycle");
    a_wait_idle: assert property (!req |-> !avs_waitrequest)
        else $error("wait without request");
    a_tag_latency: assert property (rx_valid |=> rx_tag_valid)
        else $error("tag missing after frame");
    a_tag_cause: assert property (!rx_valid |=> !rx_tag_valid)
        else $error("tag without frame");
    a_nomatch_low: assert property (rx_tag_valid && !rx_tag_matched |-> rx_tag_queue == 2'h0)
        else $error("unmatched frame not in queue 0");
    a_grant_cause: assert property (tx_grant_valid |-> rdy_q && pend_q[tx_grant_queue])
        else $error("grant without ready pending queue");
    a_grant_quiet: assert property (!tx_mac_ready || tx_pending == '0 |=> !tx_grant_valid)
        else $error("grant while mac busy or idle");
    c_read: cover property (avs_read && !avs_waitrequest);
    c_match: cover property (rx_tag_valid && rx_tag_matched);
    c_miss: cover property (rx_tag_valid && !rx_tag_matched);
    c_grant: cover property (tx_grant_valid && tx_grant_queue == 2'h3);
endmodule
`default_nettype wire

// file: epqs_mac_model.sv
// partner model: mac transmit side giving one ready pulse per kick
`timescale 1ns/1ps
`default_nettype none
module epqs_mac_model
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // control from the bench
    input  wire logic kick,
    input  wire logic slow,
    // toward the block
    output logic      tx_mac_ready
);
    // slow mode stalls four cycles, as a busy line would
    logic [2:0] cnt;
    wire  [2:0] next_cnt = kick ? (slow ? 3'h4 : 3'h1) : cnt - {2'h0, cnt != 3'h0};
    always_ff @(posedge core_clk)
    begin
        cnt          <= reset_n ? next_cnt : 3'h0;
        tx_mac_ready <= reset_n & (cnt == 3'h1);
    end
endmodule
`default_nettype wire

// file: tb_top.sv
// testbench: registers, screening and transmit grant of the screener
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rx_tag_base, tx_grant_base;
    logic avs_waitrequest, rx_tag_valid, rx_tag_matched, tx_grant_valid;
    logic rx_valid = 1'b0, rx_ds_valid = 1'b0, rx_udp_valid = 1'b0;
    logic rx_vlan_valid = 1'b0, kick = 1'b0, slow = 1'b0, tx_mac_ready;
    logic [2:0] rx_vlan_prio = 3'h0;
    logic [7:0] rx_ds = 8'h2e;
    logic [15:0] rx_ethertype = 16'h0, tx_grant_region;
    logic [31:0] rx_payload_word = 32'h0, w;
    logic [3:0] tx_pending = 4'h0;
    logic [1:0] rx_tag_queue, tx_grant_queue;
    logic [31:0] rxb[4], txb[4];
    logic [15:0] rs[4];
    logic [63:0] rq[$], xq[$], gq[$];
    int miscompares = 0, tests_run = 0;
    epqs_top u_dut (.core_clk, .reset_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
        .rx_valid, .rx_ds_valid, .rx_ds, .rx_udp_valid,
        .rx_udp_port(16'h1234), .rx_vlan_valid, .rx_vlan_prio, .rx_ethertype,
        .rx_payload_word, .rx_tag_valid, .rx_tag_queue, .rx_tag_base,
        .rx_tag_matched, .tx_pending, .tx_mac_ready, .tx_grant_valid,
        .tx_grant_queue, .tx_grant_base, .tx_grant_region);
    epqs_mac_model u_mac (.core_clk, .reset_n, .kick, .slow, .tx_mac_ready);
    always #2 core_clk = ~core_clk;
    // ------------------------------------------------------------------
    // checking
    // ------------------------------------------------------------------
    task automatic final_report;
        $display("mismatches %0d of %0d checks", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        tests_run++;
        if (s !== e)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic pop(ref logic [63:0] q[$], input logic [63:0] s);
        if (q.size() == 0)
            chk(s, ~s);
        else
            chk(s, q.pop_front());
    endtask
    always @(posedge core_clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0)
            pop(rq, {32'h0, avs_readdata});
        if (rx_tag_valid === 1'b1)
            pop(xq, {29'h0, rx_tag_queue, rx_tag_base, rx_tag_matched});
        if (tx_grant_valid === 1'b1)
            pop(gq, {14'h0, tx_grant_queue, tx_grant_base, tx_grant_region});
    end
    // ------------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------------
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        rx_valid <= 1'b0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 40)
        begin
            n++;
            @(posedge core_clk);
        end
        if (n >= 40)
        begin
            miscompares++;
            final_report;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back({32'h0, e});
        acc(1'b0, a, 32'h0);
    endtask
    // back-to-back frames: rx_valid only drops at the next bus access
    task automatic frm(input logic [2:0] f, input logic [2:0] vp, input logic [15:0] et,
                       input logic [31:0] pw, input logic [1:0] q, input logic m);
        rx_valid <= 1'b1;
        rx_ds_valid <= f[2];
        rx_udp_valid <= f[1];
        rx_vlan_valid <= f[0];
        rx_vlan_prio <= vp;
        rx_ethertype <= et;
        rx_payload_word <= pw;
        xq.push_back({29'h0, q, rxb[q], m});
        @(posedge core_clk);
    endtask
    task automatic grant(input logic [3:0] p, input logic [1:0] q, input logic s);
        int n;
        gq.push_back({14'h0, q, txb[q], rs[q]});
        tx_pending <= p;
        slow <= s;
        kick <= 1'b1;
        @(posedge core_clk);
        kick <= 1'b0;
        for (n = 0; n < 20 && gq.size() != 0; n++)
            @(posedge core_clk);
        if (gq.size() != 0)
        begin
            miscompares++;
            final_report;
        end
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hddeb));
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(12'h018, epqs_pkg::RESET_WORD);
        for (int i = 0; i < 4; i++)
        begin
            rxb[i] = $urandom;
            txb[i] = $urandom;
            rs[i] = 16'($urandom);
            acc(1'b1, i == 0 ? 12'h018 : 12'h47c + 12'(4 * i), rxb[i]);
            acc(1'b1, i == 0 ? 12'h01c : 12'h43c + 12'(4 * i), txb[i]);
            acc(1'b1, 12'h810 + 12'(4 * i), {16'h0, rs[i]});
        end
        for (int i = 0; i < 4; i++)
        begin
            rd(i == 0 ? 12'h018 : 12'h47c + 12'(4 * i), rxb[i]);
            rd(i == 0 ? 12'h01c : 12'h43c + 12'(4 * i), txb[i]);
        end
        acc(1'b1, 12'h0fc, $urandom);
        rd(12'h0fc, epqs_pkg::UNMAPPED_WORD);
        acc(1'b1, 12'h500, 32'h9000_02e2);
        acc(1'b1, 12'h504, 32'ha123_4001);
        acc(1'b1, 12'h540, 32'h8000_0153);
        frm(3'b101, 3'h5, 16'h0, 32'h0, 2'h2, 1'b1);
        frm(3'b001, 3'h5, 16'h0, 32'h0, 2'h3, 1'b1);
        frm(3'b001, 3'h4, 16'h0, 32'h0, 2'h0, 1'b0);
        frm(3'b010, 3'h0, 16'h0, 32'h0, 2'h1, 1'b1);
        // a wrong ds value must fall through to the default queue
        rx_ds <= 8'h2f;
        frm(3'b100, 3'h0, 16'h0, 32'h0, 2'h0, 1'b0);
        rx_ds <= 8'h2e;
        for (int i = 0; i < 4; i++)
            acc(1'b1, 12'h6e0 + 12'(4 * i), 32'h8800 + i);
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b1, 12'h544, 32'h8000_0801 | (i << 9));
            frm(3'b000, 3'h0, 16'(32'h8800 + i), 32'h0, 2'h1, 1'b1);
            frm(3'b000, 3'h0, 16'(32'h8800 + (i + 1) % 4), 32'h0, 2'h0, 1'b0);
        end
        w = $urandom;
        acc(1'b1, 12'h708, w);
        for (int k = 0; k < 3; k++)
        begin
            acc(1'b1, 12'h544, 32'h8000_0001 | (32'ha << (12 + 4 * k)));
            frm(3'b000, 3'h0, 16'h0, w, 2'h1, 1'b1);
            frm(3'b000, 3'h0, 16'h0, ~w, 2'h0, 1'b0);
        end
        rd(12'h820, 32'h0000_0009);
        grant(4'b1001, 2'h3, 1'b0);
        acc(1'b1, 12'h800, 32'h8);
        acc(1'b1, 12'h804, 32'h0);
        grant(4'b1001, 2'h0, 1'b1);
        acc(1'b1, 12'h804, 32'h0100_0000);
        grant(4'b1001, 2'h3, 1'b0);
        grant(4'b0110, 2'h2, 1'b1);
        final_report;
    end
endmodule
bind epqs_top epqs_sva #(.NUM_QUEUES(NUM_QUEUES)) u_sva (.core_clk, .reset_n,
    .avs_read, .avs_write, .avs_waitrequest, .rx_valid, .rx_tag_valid,
    .rx_tag_queue, .rx_tag_matched, .tx_pending, .tx_mac_ready,
    .tx_grant_valid, .tx_grant_queue);
`default_nettype wire
